// File: pkg/eag_pkg.sv
// Shared types and constants of the effective address generator.
// Assumes one synchronous clock domain shared with the instruction decoder.
`default_nettype none

package eag_pkg;

    // =========================================================
    // Enumerations
    // =========================================================
    typedef enum logic [3:0] {
        EAG_M_REG     = 4'h0,
        EAG_M_IND     = 4'h1,
        EAG_M_DISP    = 4'h2,
        EAG_M_POSTINC = 4'h3,
        EAG_M_PREDEC  = 4'h4,
        EAG_M_ABS     = 4'h5,
        EAG_M_IMM     = 4'h6,
        EAG_M_PCREL   = 4'h7,
        EAG_M_MEMIND  = 4'h8
    } eag_mode_t;

    typedef enum logic [1:0] {
        EAG_SZ_BYTE = 2'h0,
        EAG_SZ_WORD = 2'h1,
        EAG_SZ_LONG = 2'h2
    } eag_size_t;

    // Length of the extension field: displacement, absolute or immediate.
    typedef enum logic [1:0] {
        EAG_L8  = 2'h0,
        EAG_L16 = 2'h1,
        EAG_L24 = 2'h2,
        EAG_L32 = 2'h3
    } eag_len_t;

    typedef enum logic [2:0] {
        EAG_C_ALU    = 3'h0,
        EAG_C_XFER   = 3'h1,
        EAG_C_BIT    = 3'h2,
        EAG_C_BRANCH = 3'h3,
        EAG_C_JUMP   = 3'h4,
        EAG_C_ADDSUB = 3'h5,
        EAG_C_INCDEC = 3'h6,
        EAG_C_TRAP   = 3'h7
    } eag_class_t;

    typedef enum logic [1:0] {
        EAG_S_IDLE = 2'b01,
        EAG_S_PTR  = 2'b10
    } eag_state_t;

    // =========================================================
    // Constants
    // =========================================================
    localparam logic [31:0] EAG_STEP_BYTE = 32'h0000_0001;
    localparam logic [31:0] EAG_STEP_WORD = 32'h0000_0002;
    localparam logic [31:0] EAG_STEP_LONG = 32'h0000_0004;
    localparam logic [15:0] EAG_ABS8_FILL = 16'hFFFF;
    localparam logic [23:0] EAG_1MB_MASK  = 24'h0F_FFFF;
    localparam int          EAG_HALF_SEL  = 3;
    // Trap vector table base; the value is arbitrary.
    localparam logic [23:0] EAG_TRAP_BASE = 24'h00_0020;

endpackage : eag_pkg

`default_nettype wire

// File: rtl/eag_fix.sv
// Final address shaping: even forcing and 1-Mbyte truncation.
// Assumes the raw address holds the calculation result in its low bits.
`timescale 1ns/1ps
`default_nettype none

module eag_fix
    import eag_pkg::*;
(
    input  wire logic [31:0] raw_i,
    input  wire logic        even_i,
    input  wire logic        one_mb_i,
    output logic      [23:0] addr_o
);

    logic [23:0] low24;

    // =========================================================
    // Shaping
    // =========================================================
    // Only the low 24 bits ever reach the bus.
    assign low24 = raw_i[23:0];

    always_comb begin
        addr_o = low24;
        // RQ7 even forcing
        if (even_i) begin
            addr_o[0] = 1'b0;
        end
        // RQ19 1-Mbyte truncation
        if (one_mb_i) begin
            addr_o = addr_o & EAG_1MB_MASK;
        end
    end

endmodule : eag_fix

`default_nettype wire

// File: rtl/eag_step.sv
// Size-scaled step of 1, 2 or 4 and the stepped register values.
// Assumes the size code comes from the decoder on the same clock.
`timescale 1ns/1ps
`default_nettype none

module eag_step
    import eag_pkg::*;
(
    input  wire eag_size_t   size_i,
    input  wire logic [31:0] base_i,
    output logic      [31:0] step_o,
    output logic      [31:0] inc_o,
    output logic      [31:0] dec_o
);

    // =========================================================
    // Step selection
    // =========================================================
    // Byte, word and longword step by 1, 2 and 4.
    always_comb begin
        unique case (size_i)
            EAG_SZ_WORD: step_o = EAG_STEP_WORD;
            EAG_SZ_LONG: step_o = EAG_STEP_LONG;
            default:     step_o = EAG_STEP_BYTE; // Code 3 is illegal.
        endcase
    end

    // Full 32-bit sums so the register carries out of bit 23.
    assign inc_o = base_i + step_o;
    assign dec_o = base_i - step_o;

endmodule : eag_step

`default_nettype wire

// File: rtl/eag_top.sv
// Effective address generator: forms operand and branch addresses.
// Assumes decoder, register file and memory unit share clk_i.
//
// What this block does
// RQ1: Register direct selects 8-bit half, 16-bit half or full register by size.
// RQ2: Register indirect uses low 24 bits of the address register.
// RQ3: Displacement added to address register; low 24 bits form the address.
// RQ4: A 16-bit displacement is sign-extended before the addition.
// RQ5: Post-increment accesses register address, then add_small_constant 1, 2 or 4 back.
// RQ6: Pre-decrement subtracts 1, 2 or 4 first, writes back, uses result.
// RQ7: Word, longword and branch addresses have bit 0 forced to zero.
// RQ8: An 8-bit absolute address gets its upper 16 bits all ones.
// RQ9: A 16-bit absolute address sign-extends bit 15 into upper 8 bits.
// RQ10: A 24-bit absolute address is used directly.
// RQ11: Immediate operand comes from the instruction as 8, 16 or 32 bits.
// RQ12: Small-constant add/subtract and inc/dec take their constant from the opcode.
// RQ13: A 3-bit immediate field gives the bit number within the byte.
// RQ14: The trap instruction's 2-bit field selects its vector address.
// RQ15: Branch displacement of 8 or 16 bits sign-extends and add_small_constant to PC.
// RQ16: The PC base is the address of the next instruction.
// RQ17: Memory indirect pointer address is zero-extended, range 0 to 255.
// RQ18: The pointer is read as a longword; its top byte is dropped.
// RQ19: In 1-Mbyte modes the top 4 address bits are ignored.
// RQ20: ALU uses direct or immediate; transfers exclude PC-relative and indirect-memory.
// RQ21: Bit operations address by direct, indirect or 8-bit absolute.
// RQ22: A 24-bit extension is a 32-bit value with top byte zero.
// RQ23: Mode input selects 1 or 16 Mbyte; results come in one step (memory indirect waits for the pointer read instead).
`timescale 1ns/1ps
`default_nettype none

module eag_top
    import eag_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire eag_class_t  class_i,
    input  wire eag_mode_t   mode_i,
    input  wire eag_size_t   size_i,
    input  wire eag_len_t    len_i,
    input  wire logic [3:0]  reg_field_i,
    input  wire logic [31:0] general_register_i,
    input  wire logic [31:0] address_register_i,
    input  wire logic [31:0] ext_i,
    input  wire logic [23:0] pc_i,
    input  wire eag_size_t   implied_code_i,
    input  wire logic [2:0]  bit_field_i,
    input  wire logic        bit_from_reg_i,
    input  wire logic [1:0]  trap_field_i,
    input  wire logic        one_mb_i,
    input  wire logic        ptr_valid_i,
    input  wire logic [31:0] ptr_data_i,
    output logic             busy_o,
    output logic             done_o,
    output logic      [23:0] addr_o,
    output logic      [31:0] operand_o,
    output logic             wb_en_o,
    output logic      [31:0] wb_data_o,
    output logic             illegal_o,
    output logic      [2:0]  bit_num_o,
    output logic      [23:0] trap_vec_o,
    output logic             ptr_rd_o,
    output logic      [23:0] ptr_addr_o
);

    // =========================================================
    // State
    typedef struct packed {
        eag_state_t  state;
        logic        done;
        logic [23:0] addr;
        logic [31:0] operand;
        logic        wb_en;
        logic [31:0] wb_data;
        logic        illegal;
        logic [2:0]  bit_num;
        logic [23:0] trap_vec;
        logic        ptr_rd;
        logic [23:0] ptr_addr;
    } eag_regs_t;

    localparam eag_regs_t EAG_RESET = '{state: EAG_S_IDLE, default: '0};
    eag_regs_t   st_reg;
    eag_regs_t   st_next;
    logic [31:0] areg_inc;
    logic [31:0] areg_dec;
    logic [31:0] implied;
    logic [31:0] fix_raw;
    logic        fix_even;
    logic [23:0] fix_addr;
    logic [31:0] sext8;
    logic [31:0] sext16;
    logic [31:0] zext24;
    logic [31:0] gpr_sel;
    logic [31:0] raw;
    logic        even;
    logic        legal;
    logic        take;

    // =========================================================
    // Helpers
    eag_step u_step (
        .size_i (size_i),
        .base_i (address_register_i),
        .step_o (),
        .inc_o  (areg_inc),
        .dec_o  (areg_dec)
    );

    // Second stepper only maps the opcode's implied constant.
    eag_step u_implied (
        .size_i (implied_code_i),
        .base_i (32'h0000_0000),
        .step_o (implied),
        .inc_o  (),
        .dec_o  ()
    );

    eag_fix u_fix (
        .raw_i    (fix_raw),
        .even_i   (fix_even),
        .one_mb_i (one_mb_i),
        .addr_o   (fix_addr)
    );

    // Extension field forms shared by several modes.
    // RQ4 sign extension
    assign sext16 = {{16{ext_i[15]}}, ext_i[15:0]};
    assign sext8  = {{24{ext_i[7]}}, ext_i[7:0]};
    // RQ22 top byte zero
    assign zext24 = {8'h00, ext_i[23:0]};
    assign take = start_i && (st_reg.state == EAG_S_IDLE);

    // =========================================================
    // Register direct selection
    // RQ1 half register select
    always_comb begin
        unique case (size_i)
            EAG_SZ_BYTE: gpr_sel = reg_field_i[EAG_HALF_SEL]
                             ? {24'h00_0000, general_register_i[7:0]}
                             : {24'h00_0000, general_register_i[15:8]};
            EAG_SZ_WORD: gpr_sel = reg_field_i[EAG_HALF_SEL]
                             ? {16'h0000, general_register_i[31:16]}
                             : {16'h0000, general_register_i[15:0]};
            default:     gpr_sel = general_register_i;
        endcase
    end

    // =========================================================
    // Address calculation per mode
    // Modes without an address leave raw at zero; the address output
    // is then meaningless and the caller ignores it.
    always_comb begin
        raw = 32'h0000_0000;
        unique case (mode_i)
            // RQ2 register indirect
            EAG_M_IND,
            EAG_M_POSTINC: raw = address_register_i;
            // RQ3 displacement sum
            EAG_M_DISP:    raw = address_register_i
                               + ((len_i == EAG_L16) ? sext16 : zext24);
            // RQ6 pre-decrement result
            EAG_M_PREDEC:  raw = areg_dec;
            EAG_M_ABS: begin
                unique case (len_i)
                    // RQ8 ones fill
                    EAG_L8:  raw = {8'h00, EAG_ABS8_FILL, ext_i[7:0]};
                    // RQ9 sign fill
                    EAG_L16: raw = {8'h00, {8{ext_i[15]}}, ext_i[15:0]};
                    // RQ10 full address
                    default: raw = zext24;
                endcase
            end
            // RQ15 PC-relative target
            // RQ16 next-instruction base
            EAG_M_PCREL:   raw = {8'h00, pc_i + ((len_i == EAG_L8)
                                 ? sext8[23:0] : sext16[23:0])};
            default:       raw = 32'h0000_0000;
        endcase
    end

    // RQ7 word, long, branch or jump
    assign even = (size_i != EAG_SZ_BYTE)
               || (class_i == EAG_C_BRANCH)
               || (class_i == EAG_C_JUMP);

    // =========================================================
    // Mode legality per instruction class
    always_comb begin
        unique case (class_i)
            // RQ20 ALU and transfer
            EAG_C_ALU:    legal = (mode_i == EAG_M_REG)
                               || (mode_i == EAG_M_IMM);
            EAG_C_XFER:   legal = (mode_i != EAG_M_PCREL)
                               && (mode_i != EAG_M_MEMIND);
            // RQ21 bit operand modes
            EAG_C_BIT:    legal = (mode_i == EAG_M_REG)
                               || (mode_i == EAG_M_IND)
                               || ((mode_i == EAG_M_ABS)
                                   && (len_i == EAG_L8));
            EAG_C_BRANCH: legal = (mode_i == EAG_M_PCREL);
            EAG_C_JUMP:   legal = (mode_i == EAG_M_IND)
                               || (mode_i == EAG_M_ABS)
                               || (mode_i == EAG_M_MEMIND);
            default:      legal = 1'b1;
        endcase
    end

    // =========================================================
    // Next-state logic
    // Pulses fall after one cycle; results hold until the next request.
    always_comb begin
        st_next        = st_reg;
        st_next.done   = 1'b0;
        st_next.wb_en  = 1'b0;
        st_next.ptr_rd = 1'b0;
        fix_raw        = raw;
        fix_even       = even;
        unique case (st_reg.state)
            EAG_S_IDLE: begin
                if (take) begin
                    st_next.illegal = !legal;
                    st_next.addr    = fix_addr;
                    // RQ11 immediate width
                    unique case (len_i)
                        EAG_L8:  st_next.operand = {24'h00_0000, ext_i[7:0]};
                        EAG_L16: st_next.operand = {16'h0000, ext_i[15:0]};
                        EAG_L24: st_next.operand = zext24;
                        default: st_next.operand = ext_i;
                    endcase
                    if (mode_i == EAG_M_REG) begin
                        st_next.operand = gpr_sel;
                    end
                    // RQ12 implied constant
                    if ((class_i == EAG_C_ADDSUB)
                        || (class_i == EAG_C_INCDEC)) begin
                        st_next.operand = implied;
                    end
                    // RQ13 bit number
                    st_next.bit_num = bit_from_reg_i
                                    ? general_register_i[2:0]
                                    : bit_field_i;
                    // RQ14 trap vector select
                    st_next.trap_vec = EAG_TRAP_BASE
                                     + {20'h0_0000, trap_field_i, 2'b00};
                    // RQ5 post-increment write-back
                    if (mode_i == EAG_M_POSTINC) begin
                        st_next.wb_en   = 1'b1;
                        st_next.wb_data = areg_inc;
                    end
                    // RQ6 pre-decrement write-back
                    if (mode_i == EAG_M_PREDEC) begin
                        st_next.wb_en   = 1'b1;
                        st_next.wb_data = areg_dec;
                    end
                    if (mode_i == EAG_M_MEMIND) begin
                        // RQ17 zero-extended pointer
                        st_next.ptr_addr = {16'h0000, ext_i[7:1], 1'b0};
                        st_next.ptr_rd   = 1'b1;
                        st_next.state    = EAG_S_PTR;
                    end else begin
                        // RQ23 single-step result
                        st_next.done = 1'b1;
                    end
                end
            end
            EAG_S_PTR: begin
                // RQ18 drop pointer top byte
                fix_raw  = {8'h00, ptr_data_i[23:0]};
                fix_even = 1'b1;
                if (ptr_valid_i) begin
                    st_next.addr  = fix_addr;
                    st_next.done  = 1'b1;
                    st_next.state = EAG_S_IDLE;
                end
            end
            default: st_next = EAG_RESET;
        endcase
    end

    // =========================================================
    // State register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= EAG_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // All outputs come straight from the state register.
    assign busy_o     = (st_reg.state == EAG_S_PTR);
    assign done_o     = st_reg.done;
    assign addr_o     = st_reg.addr;
    assign operand_o  = st_reg.operand;
    assign wb_en_o    = st_reg.wb_en;
    assign wb_data_o  = st_reg.wb_data;
    assign illegal_o  = st_reg.illegal;
    assign bit_num_o  = st_reg.bit_num;
    assign trap_vec_o = st_reg.trap_vec;
    assign ptr_rd_o   = st_reg.ptr_rd;
    assign ptr_addr_o = st_reg.ptr_addr;

    // =========================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [23:0] h_dec1;
    logic [31:0] h_inc4;
    logic [23:0] h_ptr;
    assign h_dec1 = 24'(address_register_i - 32'h0000_0001);
    assign h_inc4 = address_register_i + 32'h0000_0004;
    assign h_ptr  = {ptr_data_i[23:1], 1'b0};
    sequence s_take;
        start_i && !busy_o;
    endsequence
    sequence s_ptr_issue;
        s_take ##0 (mode_i == EAG_M_MEMIND) ##1 ptr_rd_o && busy_o;
    endsequence
    // RQ23 one-step completion
    a_done_one_step: assert property (s_take ##0 (mode_i != EAG_M_MEMIND)
        |=> done_o && !busy_o) // RQ23
        else $error("Result not ready one cycle after request.");
    // RQ5 post-increment long
    a_postinc_wb: assert property (s_take ##0 (mode_i == EAG_M_POSTINC)
        && (size_i == EAG_SZ_LONG)
        |=> wb_en_o && (wb_data_o == $past(h_inc4))) // RQ5
        else $error("Post-increment write-back wrong.");
    // RQ6 pre-decrement byte
    a_predec_addr: assert property (s_take ##0 (mode_i == EAG_M_PREDEC)
        && (size_i == EAG_SZ_BYTE) && (class_i == EAG_C_XFER) && !one_mb_i
        |=> addr_o == $past(h_dec1)) // RQ6
        else $error("Pre-decrement address wrong.");
    // RQ8 ones fill
    a_abs8_fill: assert property (s_take ##0 (mode_i == EAG_M_ABS)
        && (len_i == EAG_L8) && !one_mb_i
        |=> addr_o[23:8] == EAG_ABS8_FILL) // RQ8
        else $error("Short absolute upper bits not all ones.");
    // RQ7 even address
    a_even_word: assert property (s_take ##0 (size_i != EAG_SZ_BYTE)
        |=> !addr_o[0]) // RQ7
        else $error("Word address left odd.");
    // RQ19 truncation
    a_onemb_trunc: assert property (s_take ##0 one_mb_i
        ##1 done_o |-> addr_o[23:20] == 4'h0) // RQ19
        else $error("1-Mbyte address has upper bits set.");
    // RQ17 pointer range
    a_ptr_range: assert property (s_ptr_issue
        |-> ptr_addr_o[23:8] == 16'h0000) // RQ17
        else $error("Pointer address above 255.");
    // RQ18 pointer target
    a_ptr_target: assert property (busy_o && ptr_valid_i && !one_mb_i
        |=> done_o && !busy_o && (addr_o == $past(h_ptr))) // RQ18
        else $error("Pointer target not taken from low 24 bits.");
    // RQ20 ALU legality
    a_alu_illegal: assert property (s_take ##0 (class_i == EAG_C_ALU)
        && (mode_i == EAG_M_ABS) |=> illegal_o [*1]) // RQ20
        else $error("ALU absolute mode not flagged.");
    // RQ13 bit number
    a_bit_num: assert property (s_take ##0 !bit_from_reg_i
        |=> bit_num_o == $past(bit_field_i)) // RQ13
        else $error("Bit number not from immediate field.");

endmodule : eag_top

`default_nettype wire

// File: test/eag_mem_model.sv
// Memory access unit model that answers pointer reads of the address generator.
// Assumes one clock; the answer delay is set per read by the bench.
`timescale 1ns/1ps
`default_nettype none

module eag_mem_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        rd_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [3:0]  lat_i,
    output logic             valid_o,
    output logic      [31:0] data_o
);
    logic       pend_reg;
    logic [3:0] cnt_reg;
    logic [7:0] lo_reg;
    // =========================================================
    // Pointer answer
    // =========================================================
    // Data flips every cycle outside the valid pulse, so a late sample never matches by chance.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_reg <= 1'b0;
            cnt_reg  <= 4'h0;
            lo_reg   <= 8'h00;
            valid_o  <= 1'b0;
            data_o   <= 32'h5A5A_5A5A;
        end else begin
            valid_o <= 1'b0;
            data_o  <= ~data_o;
            if (rd_i) begin
                pend_reg <= 1'b1;
                cnt_reg  <= lat_i;
                lo_reg   <= addr_i[7:0];
            end else if (pend_reg && cnt_reg == 4'h0) begin
                pend_reg <= 1'b0;
                valid_o  <= 1'b1;
                data_o   <= {8'hC3, 16'h4000, lo_reg + 8'h01}; // Top byte is junk the block drops.
            end else if (pend_reg) begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end
endmodule : eag_mem_model
`default_nettype wire

// File: test/eag_top_tb.sv
// Self-checking bench of the effective address generator.
// Assumes the memory model answers pointer reads.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end

module eag_top_tb;
    import eag_pkg::*;
    logic clk_i, rst_i, start_i, bit_from_reg_i, one_mb_i, ptr_valid_i;
    eag_class_t class_i;
    eag_mode_t mode_i;
    eag_size_t size_i, implied_code_i;
    eag_len_t len_i;
    logic [3:0] reg_field_i, lat;
    logic [31:0] general_register_i, address_register_i, ext_i, ptr_data_i, operand_o, wb_data_o;
    logic [23:0] pc_i, addr_o, trap_vec_o, ptr_addr_o;
    logic [2:0] bit_field_i, bit_num_o;
    logic [1:0] trap_field_i;
    logic busy_o, done_o, wb_en_o, illegal_o, ptr_rd_o;
    int error_cnt, checks_done;

    eag_top eag_top_i (.clk_i, .rst_i, .start_i, .class_i, .mode_i, .size_i, .len_i, .reg_field_i,
        .general_register_i, .address_register_i, .ext_i, .pc_i, .implied_code_i, .bit_field_i,
        .bit_from_reg_i, .trap_field_i, .one_mb_i, .ptr_valid_i, .ptr_data_i, .busy_o, .done_o,
        .addr_o, .operand_o, .wb_en_o, .wb_data_o, .illegal_o, .bit_num_o, .trap_vec_o, .ptr_rd_o,
        .ptr_addr_o);
    eag_mem_model eag_mem_model_i (.clk_i, .rst_i, .rd_i(ptr_rd_o), .addr_i(ptr_addr_o), .lat_i(lat),
        .valid_o(ptr_valid_i), .data_o(ptr_data_i));

    // Free-running 125 MHz clock.
    always #4 clk_i = ~clk_i;

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test

    // One request; a pointer fetch waits under a bound, all else must answer in one step.
    task automatic go(input bit slow);
        int i;
        @(negedge clk_i); // An edge passes, so start_i never rises in the step where it fell.
        start_i = 1'b1;
        @(negedge clk_i);
        start_i = 1'b0;
        if (!slow) `CHK("done", 1'b1, done_o)
        else `CHK("ptr_rd", 1'b1, ptr_rd_o && busy_o)
        for (i = 0; i < 30 && done_o !== 1'b1; i++) @(negedge clk_i);
        if (i == 30) begin
            error_cnt++;
            end_of_test();
        end
    endtask : go

    task automatic set(input eag_class_t c, input eag_mode_t m, input eag_size_t s, input eag_len_t l,
                       input logic [31:0] e);
        class_i = c;
        mode_i  = m;
        size_i  = s;
        len_i   = l;
        ext_i   = e;
    endtask : set

    task automatic t_reg();
        set(EAG_C_ALU, EAG_M_REG, EAG_SZ_BYTE, EAG_L8, 32'h0);
        go(0);
        `CHK("rbyte", 8'hEF, operand_o[7:0])
        `CHK("legal", 1'b0, illegal_o)
        size_i = EAG_SZ_WORD;
        go(0);
        `CHK("rword", 16'h89AB, operand_o[15:0])
        size_i = EAG_SZ_LONG;
        go(0);
        `CHK("rlong", 32'h89AB_CDEF, operand_o)
        mode_i = EAG_M_ABS;
        go(0);
        `CHK("illegal", 1'b1, illegal_o)
    endtask : t_reg

    task automatic t_auto();
        set(EAG_C_XFER, EAG_M_POSTINC, EAG_SZ_LONG, EAG_L8, 32'h0);
        address_register_i = 32'h12FF_FFFC;
        go(0);
        `CHK("pi_addr", 24'hFFFFFC, addr_o)
        `CHK("pi_wb", 32'h1300_0000, wb_data_o)
        `CHK("pi_en", 1'b1, wb_en_o)
        set(EAG_C_XFER, EAG_M_PREDEC, EAG_SZ_BYTE, EAG_L8, 32'h0);
        address_register_i = 32'h0000_0100;
        go(0);
        `CHK("pd_addr", 24'h0000FF, addr_o)
        `CHK("pd_wb", 32'h0000_00FF, wb_data_o)
        set(EAG_C_XFER, EAG_M_IND, EAG_SZ_WORD, EAG_L8, 32'h0);
        address_register_i = 32'hAB12_3457;
        go(0);
        `CHK("ind", 24'h123456, addr_o)
    endtask : t_auto

    task automatic t_disp();
        address_register_i = 32'h0000_1000;
        set(EAG_C_XFER, EAG_M_DISP, EAG_SZ_WORD, EAG_L16, 32'h0000_FFF0);
        go(0);
        `CHK("d16", 24'h000FF0, addr_o)
        set(EAG_C_XFER, EAG_M_DISP, EAG_SZ_BYTE, EAG_L24, 32'h0001_0001);
        go(0);
        `CHK("d24", 24'h011001, addr_o)
    endtask : t_disp

    task automatic t_abs();
        eag_len_t l[3] = '{EAG_L8, EAG_L16, EAG_L24};
        logic [31:0] e[3] = '{32'h12, 32'h8000, 32'h123457};
        logic [23:0] x[3] = '{24'hFFFF12, 24'hFF8000, 24'h123457};
        for (int k = 0; k < 3; k++) begin
            set(EAG_C_XFER, EAG_M_ABS, EAG_SZ_BYTE, l[k], e[k]);
            go(0);
            `CHK("abs", x[k], addr_o)
        end
        one_mb_i = 1'b1;
        ext_i = 32'hF2_3457;
        go(0);
        `CHK("abs1mb", 24'h023457, addr_o)
        one_mb_i = 1'b0;
    endtask : t_abs

    task automatic t_pc();
        pc_i = 24'h001000;
        set(EAG_C_BRANCH, EAG_M_PCREL, EAG_SZ_BYTE, EAG_L8, 32'h80);
        go(0);
        `CHK("pc8", 24'h000F80, addr_o)
        ext_i = 32'h03;
        go(0);
        `CHK("pcodd", 24'h001002, addr_o)
        class_i = EAG_C_XFER;
        go(0);
        `CHK("xfer_pc", 1'b1, illegal_o)
    endtask : t_pc

    task automatic t_mem();
        for (int k = 0; k < 2; k++) begin
            lat = k ? 4'h5 : 4'h0;
            set(EAG_C_JUMP, EAG_M_MEMIND, EAG_SZ_LONG, EAG_L8, 32'h41);
            go(1);
            `CHK("ptr_addr", 24'h000040, ptr_addr_o)
            `CHK("ind_tgt", 24'h400040, addr_o)
            `CHK("busy_end", 1'b0, busy_o)
        end
    endtask : t_mem

    task automatic t_misc();
        set(EAG_C_TRAP, EAG_M_IMM, EAG_SZ_BYTE, EAG_L8, 32'h0);
        trap_field_i = 2'h2;
        go(0);
        `CHK("trap", 24'h000028, trap_vec_o)
        set(EAG_C_BIT, EAG_M_REG, EAG_SZ_BYTE, EAG_L8, 32'h0);
        bit_field_i = 3'h5;
        go(0);
        `CHK("bitnum", 3'h5, bit_num_o)
        bit_from_reg_i = 1'b1;
        go(0);
        `CHK("bitreg", 3'h7, bit_num_o)
        bit_from_reg_i = 1'b0;
        set(EAG_C_ADDSUB, EAG_M_IMM, EAG_SZ_LONG, EAG_L8, 32'h0);
        implied_code_i = EAG_SZ_LONG;
        go(0);
        `CHK("implied", 32'h4, operand_o)
        set(EAG_C_ALU, EAG_M_IMM, EAG_SZ_LONG, EAG_L32, 32'hDEAD_BEEF);
        go(0);
        `CHK("imm", 32'hDEAD_BEEF, operand_o)
    endtask : t_misc

    // Main sequence: every input gets a value at time zero, reset for 16 cycles.
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        start_i = 1'b0;
        set(EAG_C_ALU, EAG_M_REG, EAG_SZ_BYTE, EAG_L8, 32'h0);
        reg_field_i = 4'h8;
        general_register_i = 32'h89AB_CDEF;
        address_register_i = 32'h0;
        pc_i = 24'h0;
        implied_code_i = EAG_SZ_BYTE;
        bit_field_i = 3'h0;
        bit_from_reg_i = 1'b0;
        trap_field_i = 2'h0;
        one_mb_i = 1'b0;
        lat = 4'h0;
        error_cnt = 0;
        checks_done = 0;
        repeat (16) @(negedge clk_i);
        `CHK("rst_done", 1'b0, done_o)
        rst_i = 1'b0;
        @(negedge clk_i);
        t_reg();
        t_auto();
        t_disp();
        t_abs();
        t_pc();
        t_mem();
        t_misc();
        end_of_test();
    end
endmodule : eag_top_tb
`default_nettype wire
